// ---- core/sse_exec.v ----
// Purpose: executes increment-skip, bit-skip, byte-skip and both subtracts
// Assumes: operand from data memory arrives on the instruction clock
// Notes:   fetch, decode and the rest of the instruction set live elsewhere
//
// Contract
// - increment-skip loads accumulator with operand plus one, skips on zero result
// - increment-skip never writes data memory
// - a skip inserts a dummy cycle; skipping instruction spans three cycles
// - bit-skip skips when selected operand bit is one
// - byte-skip skips when operand is non-zero, else runs next normally
// - subtract-to-accumulator writes accumulator minus operand into accumulator
// - subtract-to-memory writes accumulator minus operand back to memory
// - subtracts clear carry on borrow, set it otherwise
// - subtracts update overflow, zero, nibble, carry, compare and chained flags
// - the skip instructions leave every status flag unchanged
`default_nettype none
`include "sse_defines.vh"

module sse_exec #(
   parameter DW = `SSE_DW,
   parameter BW = `SSE_BW
) (
   // clock and reset
   input  wire                 mclk,
   input  wire                 rst,
   // instruction issue from decode
   input  wire                 op_valid,
   input  wire [`SSE_OP_W-1:0] op_code,
   input  wire [BW-1:0]        bit_sel,
   input  wire [DW-1:0]        mem_rdata,
   // accumulator load from the other instructions
   input  wire                 acc_load,
   input  wire [DW-1:0]        acc_load_data,
   // sequencing back to fetch
   output reg                  op_ready_q,
   output reg                  skip_q,
   output reg                  dummy_cycle_q,
   output reg                  done_q,
   // data memory write-back
   output reg                  mem_we_q,
   output reg  [DW-1:0]        mem_wdata_q,
   // architectural state
   output reg  [DW-1:0]        accumulator_q,
   output reg                  carry_flag_q,
   output reg                  zero_flag_q,
   output reg                  nibble_borrow_flag_q,
   output reg                  signed_overflow_flag_q,
   output reg                  signed_compare_flag_q,
   output reg                  chained_null_flag_q
);

   ////////////////////////////////////////////////////////////////////////////
   // decode

   wire                take;
   wire                is_sub_acc;
   wire                is_sub_mem;
   wire                is_sub;
   wire                is_inc;
   wire                is_skip_op;

   // an instruction is only taken while the sequencer is free
   assign take       = op_valid & op_ready_q;
   assign is_sub_acc = (op_code == `SSE_OP_SUBACC);
   assign is_sub_mem = (op_code == `SSE_OP_SUBMEM);
   assign is_sub     = is_sub_acc | is_sub_mem;
   assign is_inc     = (op_code == `SSE_OP_INCSKIP);
   assign is_skip_op = is_inc | (op_code == `SSE_OP_BITSKIP) |
                       (op_code == `SSE_OP_BYTESKIP);

   ////////////////////////////////////////////////////////////////////////////
   // datapath units

   wire [DW-1:0]       diff;
   wire                sub_carry;
   wire                sub_nib;
   wire                sub_ovf;
   wire                sub_zero;
   wire [DW-1:0]       inc_val;
   wire                skip_hit;

   // accumulator is always the minuend, memory operand the subtrahend
   sse_sub_alu #(
      .DW           (DW)
   ) u_alu (
      .minuend      (accumulator_q),
      .subtrahend   (mem_rdata),
      .diff         (diff),
      .carry        (sub_carry),
      .nib_borrow_n (sub_nib),
      .ovf          (sub_ovf),
      .zero         (sub_zero)
   );

   // skip decision shared by the three skipping instructions
   sse_skip_eval #(
      .DW      (DW),
      .BW      (BW)
   ) u_skip (
      .op      (op_code),
      .operand (mem_rdata),
      .bit_sel (bit_sel),
      .inc_val (inc_val),
      .skip    (skip_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // skip sequencer

   reg [`SSE_ST_W-1:0] state_q;
   reg [`SSE_ST_W-1:0] state_d;
   wire                skipping;

   // only a skip instruction whose condition holds stretches the sequence
   assign skipping = take & is_skip_op & skip_hit;

   // hold then dummy: with the execute cycle that makes three cycles
   always @* begin
      case (state_q)
         `SSE_ST_IDLE:  state_d = skipping ? `SSE_ST_HOLD : `SSE_ST_IDLE;
         `SSE_ST_HOLD:  state_d = `SSE_ST_DUMMY;
         `SSE_ST_DUMMY: state_d = `SSE_ST_IDLE;
         default:       state_d = `SSE_ST_IDLE;
      endcase
   end

   // state register and ready; ready drops as soon as a skip is taken
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q    <= `SSE_ST_IDLE;
         op_ready_q <= 1'b1;
      end else begin
         state_q    <= state_d;
         op_ready_q <= (state_d == `SSE_ST_IDLE);
      end
   end

   // sequencing strobes toward fetch
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         skip_q        <= 1'b0;
         dummy_cycle_q <= 1'b0;
         done_q        <= 1'b0;
      end else begin
         // skip_q pulses once when the decision is made
         skip_q        <= skipping;
         // dummy slot stands while the following instruction is discarded
         dummy_cycle_q <= (state_d == `SSE_ST_DUMMY);
         // done marks the last cycle of every instruction, skipped or not
         done_q        <= (take & ~skipping) | (state_q == `SSE_ST_HOLD);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory write-back

   // only the subtract-to-memory form writes data memory
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         mem_we_q    <= 1'b0;
         mem_wdata_q <= `SSE_ZERO;
      end else begin
         mem_we_q <= take & is_sub_mem;
         if (take & is_sub_mem) begin
            mem_wdata_q <= diff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // accumulator

   reg [DW-1:0]        acc_d;

   // increment result and the accumulator-form difference land here
   always @* begin
      acc_d = accumulator_q;
      if (take & is_inc) begin
         acc_d = inc_val;
      end else if (take & is_sub_acc) begin
         acc_d = diff;
      end else if (acc_load & ~take) begin
         acc_d = acc_load_data;
      end
   end

   // an external load loses to an instruction in the same cycle
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         accumulator_q <= `SSE_ACC_RST;
      end else begin
         accumulator_q <= acc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags

   wire                cmp_sign;

   // signed compare: true sign of the difference, corrected for overflow
   assign cmp_sign = diff[`SSE_SIGN] ^ sub_ovf;

   // flags move only on a subtract; skip forms leave them as they were
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         carry_flag_q           <= `SSE_FLAG_RST;
         zero_flag_q            <= `SSE_FLAG_RST;
         nibble_borrow_flag_q   <= `SSE_FLAG_RST;
         signed_overflow_flag_q <= `SSE_FLAG_RST;
         signed_compare_flag_q  <= `SSE_FLAG_RST;
         chained_null_flag_q    <= `SSE_FLAG_RST;
      end else if (take & is_sub) begin
         carry_flag_q           <= sub_carry;
         zero_flag_q            <= sub_zero;
         nibble_borrow_flag_q   <= sub_nib;
         signed_overflow_flag_q <= sub_ovf;
         signed_compare_flag_q  <= cmp_sign;
         // a lone subtract has no chain, so the chained flag follows zero
         chained_null_flag_q    <= sub_zero;
      end
   end

endmodule

`default_nettype wire

// ---- core/sse_skip_eval.v ----
// Purpose: skip decision for the three skipping instructions
// Assumes: operand is the memory byte as read for the instruction
// Notes:   combinational; also forms the incremented value
`default_nettype none
`include "sse_defines.vh"

module sse_skip_eval #(
   parameter DW = `SSE_DW,
   parameter BW = `SSE_BW
) (
   // instruction and operand
   input  wire [`SSE_OP_W-1:0] op,
   input  wire [DW-1:0]        operand,
   input  wire [BW-1:0]        bit_sel,
   // results
   output wire [DW-1:0]        inc_val,
   output reg                  skip
);

   // increment wraps 8'hff to zero, which is the skip case
   assign inc_val = operand + `SSE_ONE;

   // select the skip condition of each instruction
   always @* begin
      case (op)
         `SSE_OP_INCSKIP:  skip = (inc_val == `SSE_ZERO);
         `SSE_OP_BITSKIP:  skip = operand[bit_sel];
         `SSE_OP_BYTESKIP: skip = (operand != `SSE_ZERO);
         default:          skip = 1'b0;
      endcase
   end

endmodule

`default_nettype wire

// ---- core/sse_sub_alu.v ----
// Purpose: 8-bit subtractor with the full flag set of a subtraction
// Assumes: minuend is the accumulator, subtrahend the memory operand
// Notes:   purely combinational; the caller registers every result
`default_nettype none
`include "sse_defines.vh"

module sse_sub_alu #(
   parameter DW = `SSE_DW
) (
   // operands
   input  wire [DW-1:0] minuend,
   input  wire [DW-1:0] subtrahend,
   // result and flags
   output wire [DW-1:0] diff,
   output wire          carry,
   output wire          nib_borrow_n,
   output wire          ovf,
   output wire          zero
);

   wire [DW:0] full;
   wire [4:0]  low;

   // carry is the inverted borrow: set when no borrow leaves the top bit
   assign full  = {1'b0, minuend} + {1'b0, ~subtrahend} + {{DW{1'b0}}, 1'b1};
   assign diff  = full[DW-1:0];
   assign carry = full[DW];
   // nibble carry, again set when bit 3 did not borrow
   assign low          = {1'b0, minuend[`SSE_NIB_TOP:0]} + {1'b0, ~subtrahend[`SSE_NIB_TOP:0]}
                         + 5'h1;
   assign nib_borrow_n = low[4];
   // signed overflow: operand signs differ and result sign follows subtrahend
   assign ovf  = (minuend[DW-1] ^ subtrahend[DW-1]) & (diff[DW-1] ^ minuend[DW-1]);
   assign zero = (diff == {DW{1'b0}});

endmodule

`default_nettype wire

// ---- shared/sse_defines.vh ----
// Purpose: shared constants of the skip and subtract execution block
// Assumes: 8-bit data path, one instruction clock
// Notes:   included by every design file of the block
`ifndef SSE_DEFINES_VH
`define SSE_DEFINES_VH

// data width and bit-select width
`define SSE_DW          8
`define SSE_BW          3

// instruction codes on op_code
`define SSE_OP_W        3
`define SSE_OP_INCSKIP  3'h0
`define SSE_OP_BITSKIP  3'h1
`define SSE_OP_BYTESKIP 3'h2
`define SSE_OP_SUBACC   3'h3
`define SSE_OP_SUBMEM   3'h4

// reset values
`define SSE_ACC_RST     8'h00
`define SSE_FLAG_RST    1'h0

// constants of the arithmetic
`define SSE_ONE         8'h01
`define SSE_ZERO        8'h00
`define SSE_NIB_TOP     3
`define SSE_SIGN        7

// sequencer states
`define SSE_ST_W        2
`define SSE_ST_IDLE     2'h0
`define SSE_ST_HOLD     2'h1
`define SSE_ST_DUMMY    2'h2

// a skipping instruction lasts this many cycles in total
`define SSE_SKIP_CYCLES 3

`endif

// ---- testbench/sse_exec_monitor.sv ----
// Purpose: property checks of the skip and subtract block
// Assumes: sees only the ports of sse_exec
// Notes:   helper regs latch the operands of each taken op
`default_nettype none
`include "sse_defines.vh"
module sse_mon #(parameter DW = 8, parameter BW = 3) (
   // all ports of sse_exec, grouped to keep the file short
   input wire logic mclk, rst, op_valid, acc_load, op_ready_q, skip_q, dummy_cycle_q,
   input wire logic done_q, mem_we_q, carry_flag_q, zero_flag_q, nibble_borrow_flag_q,
   input wire logic signed_overflow_flag_q, signed_compare_flag_q, chained_null_flag_q,
   input wire logic [`SSE_OP_W-1:0] op_code,
   input wire logic [BW-1:0]        bit_sel,
   input wire logic [DW-1:0]        mem_rdata, acc_load_data, mem_wdata_q, accumulator_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic          tk_q, b_q;
   logic [2:0]    op_q;
   logic [DW-1:0] m_q, a_q, d;
   wire  [5:0]    fl = {carry_flag_q, zero_flag_q, nibble_borrow_flag_q,
                        signed_overflow_flag_q, signed_compare_flag_q, chained_null_flag_q};
   ////////////////////////////////////////////////////////////////////////////////
   // capture operands at the take edge, so results are checked a cycle later
   always @(posedge mclk or posedge rst) begin
      if (rst) tk_q <= 1'b0;
      else begin
         tk_q <= op_valid && op_ready_q;
         op_q <= op_code;
         m_q  <= mem_rdata;
         a_q  <= accumulator_q;
         b_q  <= mem_rdata[bit_sel];
      end
   end
   assign d = a_q - m_q;
   wire sb = tk_q && (op_q == `SSE_OP_SUBACC || op_q == `SSE_OP_SUBMEM);
   wire sk = tk_q && op_q < `SSE_OP_SUBACC;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   AST_INC: assert property (tk_q && op_q == `SSE_OP_INCSKIP |->
      accumulator_q == m_q + 8'h01 && skip_q == (m_q == 8'hFF)) else $error("inc result");
   AST_NOWR: assert property (tk_q && op_q != `SSE_OP_SUBMEM |-> !mem_we_q)
      else $error("stray memory write");
   AST_SKIP: assert property (skip_q |-> !op_ready_q ##1
      (dummy_cycle_q && done_q && !op_ready_q) ##1 op_ready_q) else $error("skip timing");
   AST_BIT: assert property (tk_q && op_q == `SSE_OP_BITSKIP |-> skip_q == b_q)
      else $error("bit skip");
   AST_BYTE: assert property (tk_q && op_q == `SSE_OP_BYTESKIP |->
      skip_q == (m_q != 8'h00)) else $error("byte skip");
   AST_SUBA: assert property (tk_q && op_q == `SSE_OP_SUBACC |-> accumulator_q == d)
      else $error("sub into acc");
   AST_SUBM: assert property (tk_q && op_q == `SSE_OP_SUBMEM |->
      mem_we_q && mem_wdata_q == d && accumulator_q == a_q) else $error("sub into mem");
   AST_CARRY: assert property (sb |-> carry_flag_q == (a_q >= m_q))
      else $error("carry");
   AST_FLAGS: assert property (sb |-> zero_flag_q == (d == 8'h00) &&
      chained_null_flag_q == zero_flag_q && nibble_borrow_flag_q == (a_q[3:0] >= m_q[3:0])
      && signed_overflow_flag_q == (a_q[7] != m_q[7] && d[7] != a_q[7])
      && signed_compare_flag_q == (d[7] ^ signed_overflow_flag_q)) else $error("sub flags");
   AST_HOLD: assert property (sk |-> $stable(fl)) else $error("skip op moved flags");
   // main scenarios reached
   cover property (skip_q);
   cover property (mem_we_q);
   cover property (sk && !skip_q);
endmodule
bind sse_exec sse_mon #(.DW(DW), .BW(BW)) sse_mon_i (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: directed tests of the skip and subtract block
// Assumes: one op in flight; results read one edge after the take
// Notes:   a refused op is offered during every skip
`default_nettype none
`include "sse_defines.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic       mclk = 0, rst = 1, op_valid = 0, acc_load = 0;
   logic [2:0] op_code = 0, bit_sel = 0;
   logic [7:0] mem_rdata = 0, acc_load_data = 0, d, a, pat = 8'hA5;
   logic [7:0] ta[6] = '{8'h05, 8'h03, 8'h80, 8'h7F, 8'h10, 8'h00};
   logic [7:0] tm[6] = '{8'h03, 8'h05, 8'h01, 8'hFF, 8'h01, 8'h00};
   wire        rdy, skp, dmy, dn, we, c, z, ac, ov, sc, cz;
   wire  [7:0] wd, acc;
   int         bad_count = 0, check_count = 0, cyc = 0;
   initial forever #5 mclk = ~mclk;
   sse_exec sse_exec_i (.mclk(mclk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
      .bit_sel(bit_sel), .mem_rdata(mem_rdata), .acc_load(acc_load),
      .acc_load_data(acc_load_data), .op_ready_q(rdy), .skip_q(skp), .dummy_cycle_q(dmy),
      .done_q(dn), .mem_we_q(we), .mem_wdata_q(wd), .accumulator_q(acc), .carry_flag_q(c),
      .zero_flag_q(z), .nibble_borrow_flag_q(ac), .signed_overflow_flag_q(ov),
      .signed_compare_flag_q(sc), .chained_null_flag_q(cz));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 1000) begin
         bad_count++;
         wrap_up;
      end
   end
   // one op; during a skip a subtract is offered and must be ignored
   task run(input logic [2:0] op, input logic [7:0] m, input logic [2:0] b, input logic sk);
      logic [5:0] f;
      @(posedge mclk);
      op_valid <= 1;
      op_code <= op;
      mem_rdata <= m;
      bit_sel <= b;
      @(posedge mclk);
      f = {c, z, ac, ov, sc, cz};
      op_valid <= 0;
      #1 chk(skp, sk, "skip");
      chk(we, op == `SSE_OP_SUBMEM, "mem write");
      if (sk) begin
         a = acc;
         @(posedge mclk);
         op_valid <= 1;
         op_code <= `SSE_OP_SUBACC;
         #1 chk({dmy, dn, rdy}, 3'b110, "dummy slot");
         @(posedge mclk);
         op_valid <= 0;
         #1 chk({rdy, acc}, {1'b1, a}, "ready, refused op");
      end
      else chk(dn, 1, "done");
      if (op < `SSE_OP_SUBACC) chk({c, z, ac, ov, sc, cz}, f, "flags held");
   endtask
   // load the accumulator, subtract, compare result and flags
   task sub(input logic [7:0] av, input logic [7:0] m, input logic tomem);
      logic v;
      @(posedge mclk);
      acc_load <= 1;
      acc_load_data <= av;
      @(posedge mclk);
      acc_load <= 0;
      run(tomem ? `SSE_OP_SUBMEM : `SSE_OP_SUBACC, m, 0, 0);
      d = av - m;
      v = (av[7] != m[7]) && (d[7] != av[7]);
      chk({tomem ? wd : acc, acc}, {d, tomem ? av : d}, "difference");
      chk(c, av >= m, "carry");
      chk({z, cz, ac, ov, sc}, {d == 0, d == 0, av[3:0] >= m[3:0], v, d[7] ^ v}, "f");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge mclk);
      rst <= 0;
      #1 chk({rdy, acc, c, z, ac, ov, sc, cz}, 15'h4000, "reset state");
      $display("test reset done");
      run(`SSE_OP_INCSKIP, 8'hFF, 0, 1);
      chk(acc, 8'h00, "inc wrap");
      run(`SSE_OP_INCSKIP, 8'h7F, 0, 0);
      chk(acc, 8'h80, "inc");
      $display("test inc-skip done");
      for (int i = 0; i < 8; i++) run(`SSE_OP_BITSKIP, pat, i[2:0], pat[i]);
      $display("test bit-skip done");
      run(`SSE_OP_BYTESKIP, 8'h00, 0, 0);
      run(`SSE_OP_BYTESKIP, 8'h80, 0, 1);
      $display("test byte-skip done");
      for (int j = 0; j < 12; j++) sub(ta[j % 6], tm[j % 6], j > 5);
      $display("test subtract done");
      wrap_up;
   end
endmodule
`default_nettype wire
